// *** tb/scd_props.sv ***
// Concurrent checks on the main serial link and the user sides of both ends.
`default_nettype none
`include "scd_defs.svh"

module scd_props (
  input wire logic        I_SYS_CLK,
  input wire logic        I_RST,
  input wire logic        host_oe,
  input wire logic        bus_level,
  input wire logic        I_CMD_VALID,
  input wire logic [15:0] I_CMD_REG,
  input wire logic        O_CMD_READY,
  input wire logic        O_CMD_REFUSED,
  input wire logic        O_EXCITE,
  input wire logic        O_POS_START,
  input wire logic        O_HOME_START,
  input wire logic        O_FWD_RUN,
  input wire logic        O_REV_RUN,
  input wire logic        O_STOP,
  input wire logic        O_CRC_ERR
);
  // ****************************************************************
  // Helper counters for bit and frame timing.
  // ****************************************************************
  logic [15:0] oe_cnt;
  logic [15:0] edge_cnt;
  logic        synced;

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RST);

  // Bit spacing is judged only after the start edge, since that edge comes in the same cycle as host_oe rises, with edge_cnt still at zero.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST || !host_oe)
    begin
      oe_cnt   <= 16'h0000;
      edge_cnt <= 16'h0000;
      synced   <= 1'b0;
    end
    else
    begin
      oe_cnt   <= oe_cnt + 16'h0001;
      edge_cnt <= $changed(bus_level) ? 16'h0000 : edge_cnt + 16'h0001;
      synced   <= synced || $changed(bus_level);
    end
  end

  // ****************************************************************
  // Properties.
  // ****************************************************************
  host_accept_a: assert property (I_CMD_VALID && O_CMD_READY && I_CMD_REG != `SCD_REG_CMD
    |=> !O_CMD_READY ##1 host_oe) else $error("host did not start a frame");
  start_bit_a: assert property ($rose(host_oe) |-> ##[0:2] !bus_level)
    else $error("no start bit");
  frame_len_a: assert property ($fell(host_oe) |-> oe_cnt >= 16'd15999 && oe_cnt <= 16'd16002)
    else $error("frame length wrong");
  bit_time_a: assert property (synced && $changed(bus_level)
    |-> (edge_cnt + 16'h0001) % 16'd200 == 16'd0) else $error("bit period wrong");
  refuse_idle_a: assert property (O_CMD_REFUSED |-> O_CMD_READY && !host_oe)
    else $error("refused request was sent");
  home_excite_a: assert property (O_HOME_START |-> O_EXCITE && !O_STOP)
    else $error("home start without excitation");
  home_once_a: assert property (O_HOME_START |=> !O_HOME_START [*8])
    else $error("home start repeated");
  pos_excite_a: assert property (O_POS_START |-> O_EXCITE && !O_STOP)
    else $error("positioning start without excitation");
  fwd_rev_a: assert property (!(O_FWD_RUN && O_REV_RUN))
    else $error("forward and reverse together");
  no_crc_err_a: assert property (!O_CRC_ERR)
    else $error("clean frame flagged bad");
endmodule

`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench joining the master and driver ends over the serial link.
`default_nettype none
`include "scd_defs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        rst;
  logic        valid;
  logic [15:0] cmd_reg;
  logic [15:0] cmd_val;
  logic        start_in;
  logic        fwd_in;
  logic        home_in;
  logic        rvs_in;
  logic        stop_in;
  logic [5:0]  din;
  logic [5:0]  data_no;
  logic        ready, done, refused, excite, pos, home, forward_run_cmd, rev, stop, crc_err;
  logic        b_pos, b_stop, b_nv, b_crc;
  logic [79:0] b_image;
  logic [7:0]  rx_sh;
  logic [7:0]  rx_q[$];
  int          seed;
  int          miscompares = 0;
  int          comparisons = 0;
  int          n_done = 0, n_ref = 0, n_home = 0, n_pos = 0, b_npos = 0, b_ncrc = 0, b_nnv = 0;
  int          rx_t = 0;

  scd_link_if link();
  scd_link_if link_bad();

  scd_host #(.GAP_CYC(400)) scd_host_i (.I_SYS_CLK(clk), .I_RST(rst), .LNK(link.host),
    .I_CMD_VALID(valid), .I_CMD_SLAVE(8'h01), .I_CMD_REG(cmd_reg), .I_CMD_VALUE(cmd_val),
    .O_CMD_READY(ready), .O_CMD_DONE(done), .O_CMD_REFUSED(refused));
  scd_device #(.GAP_CYC(400)) scd_device_i (.I_SYS_CLK(clk), .I_RST(rst), .LNK(link.dev),
    .I_SLAVE_ADDR(8'h01), .I_START_IN(start_in), .I_HOME_IN(home_in), .I_FWD_IN(fwd_in),
    .I_RVS_IN(rvs_in), .I_DATA_NO_IN(din), .I_STOP_IN(stop_in), .O_EXCITE(excite),
    .O_POS_START(pos), .O_HOME_START(home), .O_FWD_RUN(forward_run_cmd), .O_REV_RUN(rev),
    .O_DATA_NO(data_no), .O_STOP(stop), .O_NV_SAVE(), .O_NV_IMAGE(), .O_CRC_ERR(crc_err));
  // Second driver end fed by a bench driver that can corrupt frames on purpose.
  scd_device #(.GAP_CYC(400)) scd_device_bad_i (.I_SYS_CLK(clk), .I_RST(rst),
    .LNK(link_bad.dev), .I_SLAVE_ADDR(8'h01), .I_START_IN(start_in), .I_HOME_IN(home_in),
    .I_FWD_IN(fwd_in), .I_RVS_IN(rvs_in), .I_DATA_NO_IN(din), .I_STOP_IN(stop_in),
    .O_EXCITE(), .O_POS_START(b_pos), .O_HOME_START(), .O_FWD_RUN(), .O_REV_RUN(),
    .O_DATA_NO(), .O_STOP(b_stop), .O_NV_SAVE(b_nv), .O_NV_IMAGE(b_image), .O_CRC_ERR(b_crc));
  scd_props scd_props_i (.I_SYS_CLK(clk), .I_RST(rst), .host_oe(link.host_oe),
    .bus_level(link.bus_level), .I_CMD_VALID(valid), .I_CMD_REG(cmd_reg), .O_CMD_READY(ready),
    .O_CMD_REFUSED(refused), .O_EXCITE(excite), .O_POS_START(pos), .O_HOME_START(home),
    .O_FWD_RUN(forward_run_cmd), .O_REV_RUN(rev), .O_STOP(stop), .O_CRC_ERR(crc_err));

  // ****************************************************************
  // Clock, pulse counters and a line receiver sampling mid-bit.
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    n_done <= n_done + int'(done);
    n_ref  <= n_ref + int'(refused);
    n_home <= n_home + int'(home);
    n_pos  <= n_pos + int'(pos);
    b_npos <= b_npos + int'(b_pos);
    b_ncrc <= b_ncrc + int'(b_crc);
    b_nnv  <= b_nnv + int'(b_nv);
    if (rx_t == 0)
      rx_t <= (link.bus_level === 1'b0) ? 1 : 0;
    else
      rx_t <= (rx_t == 1900) ? 0 : rx_t + 1;
    if (rx_t > 200 && rx_t < 1800 && rx_t % 200 == 100)
      rx_sh <= {link.bus_level, rx_sh[7:1]};
    if (rx_t == 1900)
      rx_q.push_back(rx_sh);
  end

  // ****************************************************************
  // Expectations and bus tasks.
  // ****************************************************************
  function automatic logic [15:0] crc_of(input logic [47:0] b);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 5; i >= 0; i--)
    begin
      c = c ^ {8'h00, b[8 * i +: 8]};
      for (int j = 0; j < 8; j++)
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction

  function automatic logic [63:0] frame_of(input logic [15:0] rg, input logic [15:0] val);
    logic [15:0] c;
    c = crc_of({8'h01, 8'h06, rg, val});
    return {8'h01, 8'h06, rg, val, c[7:0], c[15:8]};
  endfunction

  task automatic check(input string nm, input logic [79:0] exp, input logic [79:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic host_write(input logic [15:0] rg, input logic [15:0] val);
    int          nf;
    int          n0;
    logic [63:0] e;
    n0 = n_done;
    nf = (val[11] && rg == `SCD_REG_CMD) ? 2 : 1;
    rx_q.delete();
    @(negedge clk);
    valid = 1'b1;
    cmd_reg = rg;
    cmd_val = val;
    @(negedge clk);
    valid = 1'b0;
    for (int k = 0; k < 40000 && n_done == n0; k++)
      @(negedge clk);
    if (n_done == n0)
    begin
      miscompares++;
      give_verdict();
    end
    repeat (4) @(negedge clk);
    check("frame_bytes", 80'(8 * nf), 80'(rx_q.size()));
    for (int f = 0; f < nf && f * 8 + 8 <= rx_q.size(); f++)
    begin
      e = frame_of(rg, (f == 0) ? val : (val & 16'hf7ff));
      for (int b = 0; b < 8; b++)
        check("wire_byte", 80'(e[63 - 8 * b -: 8]), 80'(rx_q[8 * f + b]));
    end
  endtask

  // Each bit is held 200 cycles, lsb first, framed by a low start and a high stop bit.
  task automatic raw_frame(input logic [15:0] rg, input logic [15:0] val, input logic [15:0] flip);
    logic [63:0] f;
    f = frame_of(rg, val) ^ {48'h0, flip};
    for (int b = 0; b < 8; b++)
    begin
      for (int k = 0; k < 10; k++)
      begin
        @(negedge clk);
        link_bad.host_oe = 1'b1;
        link_bad.host_out = (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : f[56 - 8 * b + k - 1];
        repeat (199) @(negedge clk);
      end
    end
    link_bad.host_oe = 1'b0;
    repeat (600) @(negedge clk);
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    seed = 2;
    rst = 1'b1;
    valid = 1'b0;
    cmd_reg = 16'h0000;
    cmd_val = 16'h0000;
    start_in = 1'b0;
    fwd_in = 1'b0;
    home_in = 1'($random(seed));
    rvs_in = 1'b0;
    stop_in = 1'b1;
    din = 6'($random(seed));
    link_bad.host_oe = 1'b0;
    link_bad.host_out = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check("crc_ref", 80'(16'hccf7), 80'(crc_of(48'h0106001e2800)));
    check("stop_break", 80'(1'b0), 80'(stop));
    check("data_no_pins", 80'(din), 80'(data_no));
    fork
      begin
        host_write(`SCD_REG_MOTION_SRC, `SCD_SRC_SERIAL);
        host_write(`SCD_REG_DATA_SRC, `SCD_SRC_SERIAL);
        check("data_no_serial", 80'(6'h00), 80'(data_no));
        @(negedge clk);
        valid = 1'b1;
        cmd_reg = `SCD_REG_CMD;
        cmd_val = 16'h2800;
        @(negedge clk);
        valid = 1'b0;
        repeat (3) @(negedge clk);
        check("home_refused", 80'(1), 80'(n_ref));
        host_write(`SCD_REG_CMD, 16'h2000);
        check("excite_on", 80'(1'b1), 80'(excite));
        start_in = 1'b1;
        repeat (4) @(negedge clk);
        start_in = 1'b0;
        repeat (4) @(negedge clk);
        check("start_pin", 80'(1), 80'(n_pos));
        fwd_in = 1'b1;
        rvs_in = 1'b1;
        home_in = 1'b1;
        host_write(`SCD_REG_CMD, 16'h2800);
        check("home_once", 80'(1), 80'(n_home));
        check("fwd_pin_ignored", 80'(1'b0), 80'(forward_run_cmd));
        din = 6'($random(seed));
        host_write(`SCD_REG_CMD, 16'h2201);
        check("fwd_run", 80'(1'b1), 80'(forward_run_cmd));
        check("data_no_one", 80'(6'h01), 80'(data_no));
      end
      begin
        raw_frame(`SCD_REG_START_SRC, `SCD_SRC_SERIAL, 16'h0000);
        raw_frame(`SCD_REG_CMD, 16'h2000, 16'h0000);
        raw_frame(`SCD_REG_CMD, 16'h2101, 16'h0000);
        check("pos_serial", 80'(1), 80'(b_npos));
        raw_frame(`SCD_REG_STOP_POL, `SCD_STOP_MAKE, 16'h0100);
        check("crc_dropped", 80'(1), 80'(b_ncrc));
        check("stop_kept", 80'(1'b0), 80'(b_stop));
        raw_frame(`SCD_REG_STOP_POL, `SCD_STOP_MAKE, 16'h0000);
        check("stop_make", 80'(1'b1), 80'(b_stop));
        raw_frame(`SCD_REG_NV_SAVE, 16'h0001, 16'h0000);
        check("nv_saved", 80'(1), 80'(b_nnv));
        check("nv_image", {16'h2101, 16'h0000, 16'h0000, 16'h0001, 16'h0001}, b_image);
      end
    join
    give_verdict();
  end
endmodule

`default_nettype wire

// *** verilog/scd_defs.svh ***
// Constants shared by both ends of the serial command port.
`ifndef SCD_DEFS_SVH
`define SCD_DEFS_SVH

// ****************************************************************
// Register offsets and command word fields.
// ****************************************************************
`define SCD_REG_CMD         16'h001e
`define SCD_REG_START_SRC   16'h1c00
`define SCD_REG_STOP_POL    16'h1c03
`define SCD_REG_MOTION_SRC  16'h1c0c
`define SCD_REG_DATA_SRC    16'h1c0d
`define SCD_REG_NV_SAVE     16'h3e85
`define SCD_FN_WRITE_SINGLE 8'h06
`define SCD_ADDR_BROADCAST  8'h00
`define SCD_BIT_START       8
`define SCD_BIT_FWD         9
`define SCD_BIT_RVS         10
`define SCD_BIT_HOME        11
`define SCD_BIT_STOP        12
`define SCD_BIT_EXCITE      13
`define SCD_DATA_NO_W       6

// ****************************************************************
// Values of the volatile parameters; reset loads SCD_SRC_DISCRETE, SCD_STOP_BREAK and SCD_CMD_RESET.
// ****************************************************************
`define SCD_SRC_SERIAL      16'h0000
`define SCD_SRC_DISCRETE    16'h0001
`define SCD_STOP_MAKE       16'h0000
`define SCD_STOP_BREAK      16'h0001
`define SCD_CMD_RESET       16'h0000

// ****************************************************************
// Link timing and frame layout.
// ****************************************************************
`define SCD_CLK_HZ          125000000
`define SCD_BAUD_BPS        625000
`define SCD_BIT_CYC         (`SCD_CLK_HZ / `SCD_BAUD_BPS)
`define SCD_HALF_CYC        (`SCD_BIT_CYC / 2)
`define SCD_GAP_BITS        35
`define SCD_FRAME_LEN       8
`define SCD_BODY_LEN        6
`define SCD_NBYTE_DEAD      4'hf
`define SCD_CRC_INIT        16'hffff
`define SCD_CRC_POLY        16'ha001

`endif

// *** verilog/scd_device.sv ***
// Driver end: receives register writes and steers the motion commands.
`default_nettype none
`include "scd_defs.svh"

module scd_device #(
  parameter int GAP_CYC = `SCD_GAP_BITS * `SCD_BIT_CYC
) (
  input  wire logic                       I_SYS_CLK,
  input  wire logic                       I_RST,
  scd_link_if.dev                         LNK,
  input  wire logic [7:0]                 I_SLAVE_ADDR,
  input  wire logic                       I_START_IN,
  input  wire logic                       I_HOME_IN,
  input  wire logic                       I_FWD_IN,
  input  wire logic                       I_RVS_IN,
  input  wire logic [`SCD_DATA_NO_W-1:0]  I_DATA_NO_IN,
  input  wire logic                       I_STOP_IN,
  output var  logic                       O_EXCITE,
  output var  logic                       O_POS_START,
  output var  logic                       O_HOME_START,
  output var  logic                       O_FWD_RUN,
  output var  logic                       O_REV_RUN,
  output var  logic [`SCD_DATA_NO_W-1:0]  O_DATA_NO,
  output var  logic                       O_STOP,
  output var  logic                       O_NV_SAVE,
  output var  logic [79:0]                O_NV_IMAGE,
  output var  logic                       O_CRC_ERR
);

  scd_pkg::scd_dev_state_t s;
  scd_pkg::scd_dev_state_t next_s;

  logic        byte_done;
  logic [3:0]  idx;
  logic [15:0] crc_in;
  logic [15:0] wr_reg;
  logic [15:0] wr_val;
  logic        stop_lvl;
  logic        start_lvl;
  logic        home_lvl;
  logic        fwd_lvl;
  logic        rvs_lvl;

  // ****************************************************************
  // Receiver, frame check and register writes.
  // ****************************************************************
  always_comb
  begin
    next_s    = s;
    byte_done = 1'b0;
    idx       = 4'h0;
    crc_in    = `SCD_CRC_INIT;
    wr_reg    = {s.body[2], s.body[3]};
    wr_val    = {s.body[4], s.body[5]};
    next_s.pos_start  = 1'b0;
    next_s.home_start = 1'b0;
    next_s.nv_save    = 1'b0;
    next_s.crc_err    = 1'b0;
    // Only idle line time counts, so a long byte never passes for a frame gap.
    if ((s.rx == scd_pkg::SCD_RX_IDLE) && (s.gap != 16'(GAP_CYC)))
    begin
      next_s.gap = s.gap + 16'h0001;
    end
    // Bit timing follows the fixed link rate.
    case (s.rx)
      scd_pkg::SCD_RX_IDLE:
      begin
        if (!LNK.bus_level)
        begin
          next_s.rx   = scd_pkg::SCD_RX_START;
          next_s.baud = 8'h00;
        end
      end
      scd_pkg::SCD_RX_START:
      begin
        if (s.baud == 8'(`SCD_HALF_CYC - 1))
        begin
          next_s.baud = 8'h00;
          next_s.bitn = 3'h0;
          // A glitch shorter than half a bit is not a start bit.
          next_s.rx   = LNK.bus_level ? scd_pkg::SCD_RX_IDLE : scd_pkg::SCD_RX_DATA;
        end
        else
        begin
          next_s.baud = s.baud + 8'h01;
        end
      end
      scd_pkg::SCD_RX_DATA:
      begin
        if (s.baud == 8'(`SCD_BIT_CYC - 1))
        begin
          next_s.baud  = 8'h00;
          next_s.shift = {LNK.bus_level, s.shift[7:1]};
          next_s.bitn  = s.bitn + 3'h1;
          if (s.bitn == 3'h7)
          begin
            next_s.rx = scd_pkg::SCD_RX_STOP;
          end
        end
        else
        begin
          next_s.baud = s.baud + 8'h01;
        end
      end
      default:
      begin
        if (s.baud == 8'(`SCD_BIT_CYC - 1))
        begin
          next_s.rx   = scd_pkg::SCD_RX_IDLE;
          next_s.baud = 8'h00;
          next_s.gap  = 16'h0000;
          byte_done   = 1'b1;
          // A missing stop bit spoils the whole frame.
          if (!LNK.bus_level)
          begin
            byte_done    = 1'b0;
            next_s.nbyte = `SCD_NBYTE_DEAD;
          end
        end
        else
        begin
          next_s.baud = s.baud + 8'h01;
        end
      end
    endcase

    if (byte_done)
    begin
      // A silent gap marks the start of a new frame.
      idx = (s.gap == 16'(GAP_CYC)) ? 4'h0 : s.nbyte;
      if (idx != 4'h0)
      begin
        crc_in = s.crc;
      end
      if (idx < 4'(`SCD_BODY_LEN))
      begin
        next_s.body[idx[2:0]] = s.shift;
        next_s.crc            = scd_pkg::crc16_byte(crc_in, s.shift);
        next_s.nbyte          = idx + 4'h1;
      end
      else if (idx == 4'(`SCD_BODY_LEN))
      begin
        next_s.nbyte   = (s.shift == s.crc[7:0]) ? idx + 4'h1 : `SCD_NBYTE_DEAD;
        next_s.crc_err = (s.shift != s.crc[7:0]);
      end
      else if (idx == 4'(`SCD_FRAME_LEN - 1))
      begin
        next_s.nbyte   = `SCD_NBYTE_DEAD;
        next_s.crc_err = (s.shift != s.crc[15:8]);
        // Only a checked single-register write addressed here or to the broadcast address acts.
        if ((s.shift == s.crc[15:8]) && (s.body[1] == `SCD_FN_WRITE_SINGLE)
            && ((s.body[0] == I_SLAVE_ADDR) || (s.body[0] == `SCD_ADDR_BROADCAST)))
        begin
          if (wr_reg == `SCD_REG_CMD)
          begin
            next_s.cmd = wr_val;
          end
          else if (wr_reg == `SCD_REG_START_SRC)
          begin
            next_s.start_src = wr_val;
          end
          else if (wr_reg == `SCD_REG_STOP_POL)
          begin
            next_s.stop_pol = wr_val;
          end
          else if (wr_reg == `SCD_REG_MOTION_SRC)
          begin
            next_s.motion_src = wr_val;
          end
          else if (wr_reg == `SCD_REG_DATA_SRC)
          begin
            next_s.data_src = wr_val;
          end
          else if (wr_reg == `SCD_REG_NV_SAVE)
          begin
            next_s.nv_save  = 1'b1;
            next_s.nv_image = {s.cmd, s.start_src, s.stop_pol, s.motion_src, s.data_src};
          end
        end
      end
    end

    // ****************************************************************
    // Command sources and motion outputs.
    // ****************************************************************
    stop_lvl  = ((s.stop_pol == `SCD_STOP_MAKE) ? I_STOP_IN : !I_STOP_IN)
                | s.cmd[`SCD_BIT_STOP];
    start_lvl = (s.start_src == `SCD_SRC_SERIAL) ? s.cmd[`SCD_BIT_START] : I_START_IN;
    home_lvl  = (s.motion_src == `SCD_SRC_SERIAL) ? s.cmd[`SCD_BIT_HOME] : I_HOME_IN;
    fwd_lvl   = (s.motion_src == `SCD_SRC_SERIAL) ? s.cmd[`SCD_BIT_FWD] : I_FWD_IN;
    rvs_lvl   = (s.motion_src == `SCD_SRC_SERIAL) ? s.cmd[`SCD_BIT_RVS] : I_RVS_IN;
    next_s.prev_start = start_lvl;
    next_s.prev_home  = home_lvl;
    next_s.excite     = s.cmd[`SCD_BIT_EXCITE];
    next_s.stop       = stop_lvl;
    // Starts act on the rising edge only, so clearing the bit never restarts.
    next_s.pos_start  = start_lvl & !s.prev_start & s.cmd[`SCD_BIT_EXCITE] & !stop_lvl;
    next_s.home_start = home_lvl & !s.prev_home & s.cmd[`SCD_BIT_EXCITE] & !stop_lvl;
    // Both directions at once is treated as neither, which decelerates to rest.
    next_s.forward_run_cmd = fwd_lvl & !rvs_lvl & s.cmd[`SCD_BIT_EXCITE] & !stop_lvl;
    next_s.rev = rvs_lvl & !fwd_lvl & s.cmd[`SCD_BIT_EXCITE] & !stop_lvl;
    next_s.data_no = (s.data_src == `SCD_SRC_SERIAL)
                     ? s.cmd[`SCD_DATA_NO_W-1:0] : I_DATA_NO_IN;
  end

  // Parameters come back to their defaults at every reset, as after power-up.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      s            <= '0;
      s.gap        <= 16'(GAP_CYC);
      s.cmd        <= `SCD_CMD_RESET;
      s.start_src  <= `SCD_SRC_DISCRETE;
      s.stop_pol   <= `SCD_STOP_BREAK;
      s.motion_src <= `SCD_SRC_DISCRETE;
      s.data_src   <= `SCD_SRC_DISCRETE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign O_EXCITE     = s.excite;
  assign O_POS_START  = s.pos_start;
  assign O_HOME_START = s.home_start;
  assign O_FWD_RUN    = s.forward_run_cmd;
  assign O_REV_RUN    = s.rev;
  assign O_DATA_NO    = s.data_no;
  assign O_STOP       = s.stop;
  assign O_NV_SAVE    = s.nv_save;
  assign O_NV_IMAGE   = s.nv_image;
  assign O_CRC_ERR    = s.crc_err;

endmodule

`default_nettype wire

// *** verilog/scd_host.sv ***
// Master end: frames register writes and sends them on the serial line.
`default_nettype none
`include "scd_defs.svh"

module scd_host #(
  parameter int GAP_CYC = `SCD_GAP_BITS * `SCD_BIT_CYC
) (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST,
  scd_link_if.host         LNK,
  input  wire logic        I_CMD_VALID,
  input  wire logic [7:0]  I_CMD_SLAVE,
  input  wire logic [15:0] I_CMD_REG,
  input  wire logic [15:0] I_CMD_VALUE,
  output var  logic        O_CMD_READY,
  output var  logic        O_CMD_DONE,
  output var  logic        O_CMD_REFUSED
);

  scd_pkg::scd_host_state_t_s_t s;
  scd_pkg::scd_host_state_t_s_t next_s;

  logic [7:0] cur;

  // Every frame is a single-register write closed by its check word.
  function automatic logic [7:0][7:0] make_frame(input logic [7:0]  slave,
                                                 input logic [15:0] rg,
                                                 input logic [15:0] val);
    logic [7:0][7:0] f;
    logic [15:0]     c;
    f = {8'h00, 8'h00, val[7:0], val[15:8], rg[7:0], rg[15:8], `SCD_FN_WRITE_SINGLE, slave};
    c = `SCD_CRC_INIT;
    for (int i = 0; i < `SCD_BODY_LEN; i++)
    begin
      c = scd_pkg::crc16_byte(c, f[i]);
    end
    f[6] = c[7:0];
    f[7] = c[15:8];
    return f;
  endfunction

  // ****************************************************************
  // Request intake, transmitter and inter-frame gap.
  // ****************************************************************
  always_comb
  begin
    next_s         = s;
    next_s.done    = 1'b0;
    next_s.refused = 1'b0;
    cur            = s.frame[s.nbyte];
    case (s.state)
      scd_pkg::SCD_H_IDLE:
      begin
        if (I_CMD_VALID)
        begin
          // Homing without excitation already written is refused.
          if ((I_CMD_REG == `SCD_REG_CMD) && I_CMD_VALUE[`SCD_BIT_HOME]
              && !s.last_cmd[`SCD_BIT_EXCITE])
          begin
            next_s.refused = 1'b1;
          end
          else
          begin
            next_s.frame = make_frame(I_CMD_SLAVE, I_CMD_REG, I_CMD_VALUE);
            next_s.state = scd_pkg::SCD_H_SEND;
            next_s.baud  = 8'h00;
            next_s.bitn  = 4'h0;
            next_s.nbyte = 3'h0;
            if (I_CMD_REG == `SCD_REG_CMD)
            begin
              next_s.last_cmd      = I_CMD_VALUE;
              next_s.clear_pending = I_CMD_VALUE[`SCD_BIT_HOME];
            end
          end
        end
      end
      scd_pkg::SCD_H_SEND:
      begin
        next_s.oe  = 1'b1;
        next_s.out = (s.bitn == 4'h0) ? 1'b0 : (s.bitn == 4'h9) ? 1'b1 : cur[s.bitn[2:0] - 3'h1];
        // One start bit, eight data bits lsb first, one stop bit.
        if (s.baud == 8'(`SCD_BIT_CYC - 1))
        begin
          next_s.baud = 8'h00;
          next_s.bitn = s.bitn + 4'h1;
          if (s.bitn == 4'h9)
          begin
            next_s.bitn  = 4'h0;
            next_s.nbyte = s.nbyte + 3'h1;
            if (s.nbyte == 3'(`SCD_FRAME_LEN - 1))
            begin
              next_s.state = scd_pkg::SCD_H_GAP;
              next_s.gap   = 16'h0000;
            end
          end
        end
        else
        begin
          next_s.baud = s.baud + 8'h01;
        end
      end
      default:
      begin
        next_s.oe  = 1'b0;
        next_s.out = 1'b1;
        if (s.gap == 16'(GAP_CYC))
        begin
          if (s.clear_pending)
          begin
            // Drop the home bit again, keeping excitation and the rest.
            next_s.last_cmd      = s.last_cmd & ~(16'h0001 << `SCD_BIT_HOME);
            next_s.frame         = make_frame(s.frame[0], `SCD_REG_CMD, next_s.last_cmd);
            next_s.clear_pending = 1'b0;
            next_s.state         = scd_pkg::SCD_H_SEND;
            next_s.baud          = 8'h00;
            next_s.bitn          = 4'h0;
            next_s.nbyte         = 3'h0;
          end
          else
          begin
            next_s.state = scd_pkg::SCD_H_IDLE;
            next_s.done  = 1'b1;
          end
        end
        else
        begin
          next_s.gap = s.gap + 16'h0001;
        end
      end
    endcase
    next_s.ready = (next_s.state == scd_pkg::SCD_H_IDLE);
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      s       <= '0;
      s.out   <= 1'b1;
      s.ready <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign LNK.host_out  = s.out;
  assign LNK.host_oe   = s.oe;
  assign O_CMD_READY   = s.ready;
  assign O_CMD_DONE    = s.done;
  assign O_CMD_REFUSED = s.refused;

endmodule

`default_nettype wire

// *** verilog/scd_link_if.sv ***
// Half-duplex serial line between the master and the driver.
`default_nettype none

interface scd_link_if;
  logic host_out;
  logic host_oe;
  wire  bus_level;

  // The line idles high through its bias network when nobody drives it.
  assign bus_level = host_oe ? host_out : 1'b1;

  modport host (output host_out, output host_oe, input bus_level);
  modport dev  (input bus_level);
endinterface

`default_nettype wire

// *** verilog/scd_pkg.sv ***
// Types and the frame check function shared by both ends.
`default_nettype none
`include "scd_defs.svh"

package scd_pkg;

  typedef enum logic [1:0] {SCD_RX_IDLE, SCD_RX_START, SCD_RX_DATA, SCD_RX_STOP} scd_rx_state_t;
  typedef enum logic [1:0] {SCD_H_IDLE, SCD_H_SEND, SCD_H_GAP} scd_host_state_t;

  typedef struct packed {
    scd_rx_state_t   rx;
    logic [7:0]      baud;
    logic [2:0]      bitn;
    logic [7:0]      shift;
    logic [3:0]      nbyte;
    logic [15:0]     gap;
    logic [5:0][7:0] body;
    logic [15:0]     crc;
    logic [15:0]     cmd;
    logic [15:0]     start_src;
    logic [15:0]     stop_pol;
    logic [15:0]     motion_src;
    logic [15:0]     data_src;
    logic            prev_start;
    logic            prev_home;
    logic            excite;
    logic            pos_start;
    logic            home_start;
    logic            forward_run_cmd;
    logic            rev;
    logic [5:0]      data_no;
    logic            stop;
    logic            nv_save;
    logic [79:0]     nv_image;
    logic            crc_err;
  } scd_dev_state_t;

  typedef struct packed {
    scd_host_state_t state;
    logic [7:0]      baud;
    logic [3:0]      bitn;
    logic [2:0]      nbyte;
    logic [15:0]     gap;
    logic [7:0][7:0] frame;
    logic [15:0]     last_cmd;
    logic            clear_pending;
    logic            out;
    logic            oe;
    logic            ready;
    logic            done;
    logic            refused;
  } scd_host_state_t_s_t;

  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ `SCD_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

`default_nettype wire
